/* swc_pkg.sv */
// constants, register map and state type of the sleep/wake-up controller
package swc_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS  = 10000;
  localparam int TOSC_PS        = 10000;  // oscillator period: our clock
  localparam int OST_TOSC       = 1024;   // start-up delay in osc periods
  localparam int OST_CYCLES     = (OST_TOSC * TOSC_PS + CLK_PERIOD_PS - 1)
                                  / CLK_PERIOD_PS;
  localparam int OST_CNT_W      = 11;

  // ----------------------------------------------------------------
  // instruction set subset
  // ----------------------------------------------------------------
  localparam logic [13:0] SLEEP_OPCODE   = 14'h0063;
  localparam logic [13:0] WDT_CLR_OPCODE = 14'h0064;
  localparam logic [12:0] IRQ_VECTOR     = 13'h0004;
  localparam logic [12:0] PC_STEP        = 13'h0001;

  // ----------------------------------------------------------------
  // wake-capable interrupt sources
  // ----------------------------------------------------------------
  localparam int SRC_EXT_IRQ  = 0;
  localparam int SRC_PORT_CHG = 1;
  localparam int SRC_ADC      = 2;
  localparam int NUM_SRC      = 3;

  // ----------------------------------------------------------------
  // register map (8-bit data, 2-bit address)
  // ----------------------------------------------------------------
  localparam logic [1:0] ADDR_CTRL     = 2'h0;
  localparam logic [1:0] ADDR_FLAGS    = 2'h1;
  localparam logic [1:0] ADDR_IRQ_STAT = 2'h2;
  localparam logic [1:0] ADDR_IRQ_MASK = 2'h3;

  // ctrl fields
  localparam int CTRL_OSC_LSB = 0;   // [2:0] oscillator mode
  localparam int CTRL_WDT_EN  = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // oscillator mode codes
  localparam logic [2:0] OSC_CRYSTAL = 3'h0;
  localparam logic [2:0] OSC_HIGH_SPEED = 3'h1;
  localparam logic [2:0] OSC_LOW_POWER = 3'h2;
  localparam logic [2:0] OSC_INT_RC  = 3'h3;
  localparam logic [2:0] OSC_EXT_RC  = 3'h4;

  // flags fields (status bit positions kept)
  localparam int FLG_ASLEEP   = 0;
  localparam int FLG_PWR_DOWN = 3;
  localparam int FLG_TIMEOUT  = 4;

  // event bits of irq status and mask
  localparam int EV_SLEEP    = 0;
  localparam int EV_SLP_NOP  = 1;
  localparam int EV_WAKE_IRQ = 2;
  localparam int EV_WAKE_WDT = 3;
  localparam int EV_EXT_RST  = 4;
  localparam int NUM_EV      = 5;
  localparam logic [NUM_EV-1:0] MASK_RESET = 5'h00;

  typedef enum logic [2:0] {
    ST_RUN, ST_SLEEP, ST_OST, ST_EXEC, ST_DUMMY1, ST_DUMMY2
  } swc_state_type;

endpackage

/* swc_sleep_ctrl.sv */
// sleep entry, wake-up and oscillator start-up control for the core
//
// Notes on behaviour
// [R1] sleep clears watchdog (still running), clears power_down, sets timeout, osc off
// [R2] port pins hold their pre-sleep drive, level and enable while asleep
// [R3] wake on reset pin, enabled watchdog timeout, or permitted interrupts
// [R4] reset pin gives full reset; other wake sources resume without reset
// [R5] watchdog timeout wake clears the timeout flag
// [R6] power_down flag set at power-up, cleared by every sleep instruction not taken as a no-op
// [R7] only converter-done on internal RC clock may wake among peripherals
// [R8] during sleep instruction the core prefetches PC + 1
// [R9] interrupt wakes only when its enable is set; global enable irrelevant
// [R10] global enable off: continue in line; on: run next, vector 0004h
// [R11] pending enabled flag before sleep, global off: sleep is no-op
// [R12] interrupt during/after sleep: full sleep effects, then wake at once
// [R13] crystal, high-speed, low-power modes wait 1024 osc periods on wake
// [R14] decode 14'h0063 as one-cycle sleep instruction touching both flags
// [R15] decode 14'h0064 as one-cycle watchdog clear touching both flags
// [R16] reset pin in sleep or irq wake leaves timeout 1, power_down 0
// [R17] two dummy cycles between prefetched instruction and vector fetch
module swc_sleep_ctrl (
  input  wire logic                     clk_sys_in,        // 100 MHz
  input  wire logic                     rstn_in,           // power-on reset
  input  wire logic                     external_reset_pin_n_in, // pin
  input  wire logic                     instr_exec_in,     // execute strobe
  input  wire logic [13:0]              instr_in,          // opcode
  input  wire logic [12:0]              pc_in,             // its address
  input  wire logic                     global_irq_enable_in, // core flag
  input  wire logic [swc_pkg::NUM_SRC-1:0] irq_flag_in,    // source flags
  input  wire logic [swc_pkg::NUM_SRC-1:0] irq_enable_in,  // source enables
  input  wire logic                     adc_rc_clock_in,   // converter on rc
  input  wire logic                     wdt_timeout_in,    // watchdog expiry
  input  wire logic [5:0]               port_data_in,      // core port data
  input  wire logic [5:0]               port_oe_in,        // core port enable
  input  wire logic [1:0]               reg_addr_in,       // register addr
  input  wire logic [7:0]               reg_wdata_in,      // write data
  input  wire logic                     reg_wr_in,         // write strobe
  input  wire logic                     reg_rd_in,         // read strobe
  output logic      [7:0]               reg_rdata_out,     // read data
  output logic                          irq_out,           // level irq
  output logic                          device_reset_out,  // full reset
  output logic                          core_run_out,      // phase clocks on
  output logic                          osc_driver_en_out, // osc driver
  output logic                          wdt_clear_out,     // watchdog clear
  output logic                          power_down_flag_out, // status<3>
  output logic                          timeout_flag_out,  // status<4>
  output logic                          prefetch_req_out,  // fetch pulse
  output logic      [12:0]              prefetch_addr_out, // fetch address
  output logic                          exec_prefetched_out, // run fetched
  output logic                          dummy_cycle_out,   // dummy slot
  output logic                          vector_req_out,    // vector pulse
  output logic      [12:0]              vector_addr_out,   // vector address
  output logic      [5:0]               port_data_out,     // held pin data
  output logic      [5:0]               port_oe_out        // held pin enable
);
  import swc_pkg::*;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  logic rst_pin_meta_q;
  logic rst_pin_sync_q;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_pin_meta_q <= 1'b1;
      rst_pin_sync_q <= 1'b1;
    end else begin
      rst_pin_meta_q <= external_reset_pin_n_in;
      rst_pin_sync_q <= rst_pin_meta_q;
    end
  end

  wire logic ext_rst = !rst_pin_sync_q;

  // ----------------------------------------------------------------
  // decode and wake conditions
  // ----------------------------------------------------------------
  swc_state_type state_q;
  swc_state_type state_d;
  logic [7:0]           ctrl_q;
  logic [OST_CNT_W-1:0] ost_cnt_q;
  logic                 wake_irq_q;

  wire logic [2:0] osc_mode = ctrl_q[CTRL_OSC_LSB +: 3];
  wire logic       wdt_en   = ctrl_q[CTRL_WDT_EN];

  wire logic sleep_op  = instr_exec_in && (instr_in == SLEEP_OPCODE);   // R14
  wire logic wdt_clr_op = instr_exec_in && (instr_in == WDT_CLR_OPCODE); // R15

  logic [NUM_SRC-1:0] src_allowed;
  always_comb begin
    src_allowed = '1;
    src_allowed[SRC_ADC] = adc_rc_clock_in; // R7
  end

  // gated per source enable, and the converter also by its rc clock; the global enable takes no part
  wire logic irq_pending = |(irq_flag_in & irq_enable_in & src_allowed); // R9
  wire logic wdt_wake    = wdt_en && wdt_timeout_in;                   // R3

  wire logic in_run   = (state_q == ST_RUN);
  wire logic sleep_nop  = in_run && sleep_op && !global_irq_enable_in
                          && irq_pending;                                // R11
  wire logic sleep_take = in_run && sleep_op && !sleep_nop;              // R12
  wire logic clr_take   = in_run && wdt_clr_op;

  wire logic asleep   = (state_q == ST_SLEEP);
  wire logic wake_evt = asleep && !ext_rst && (irq_pending || wdt_wake); // R3
  wire logic osc_slow = (osc_mode == OSC_CRYSTAL) ||
                        (osc_mode == OSC_HIGH_SPEED) ||
                        (osc_mode == OSC_LOW_POWER);
  wire logic ost_done = (ost_cnt_q == OST_CNT_W'(OST_CYCLES - 1));

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_RUN:    if (sleep_take) state_d = ST_SLEEP;                     // R1
      ST_SLEEP:  if (wake_evt) state_d = osc_slow ? ST_OST : ST_EXEC;   // R13
      ST_OST:    if (ost_done) state_d = ST_EXEC;                        // R13
      ST_EXEC:   state_d = (wake_irq_q && global_irq_enable_in) ?
                           ST_DUMMY1 : ST_RUN;                           // R10
      ST_DUMMY1: state_d = ST_DUMMY2;                                    // R17
      ST_DUMMY2: state_d = ST_RUN;                                       // R17
    endcase
    // pin reset always wins and returns to a fresh run
    if (ext_rst) state_d = ST_RUN;                                       // R4
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ost_cnt_q <= '0;
    end else if (state_q == ST_OST) begin
      ost_cnt_q <= ost_cnt_q + OST_CNT_W'(1);                            // R13
    end else begin
      ost_cnt_q <= '0;
    end
  end

  // an interrupt wake may branch to the vector; a watchdog wake never does
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wake_irq_q <= 1'b0;
    end else if (wake_evt) begin
      wake_irq_q <= irq_pending;
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  logic pd_q;
  logic to_q;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pd_q <= 1'b1;                                                      // R6
    end else if (sleep_take) begin
      pd_q <= 1'b0;                                                      // R6
    end else if (clr_take) begin
      pd_q <= 1'b1;                                                      // R15
    end
  end

  // pin reset and irq wake leave both flags untouched
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      to_q <= 1'b1;
    end else if (wdt_en && wdt_timeout_in) begin
      to_q <= 1'b0;                                                      // R5
    end else if (sleep_take || clr_take) begin
      to_q <= 1'b1;                                                      // R1
    end
  end

  assign power_down_flag_out = pd_q;                                     // R16
  assign timeout_flag_out    = to_q;                                     // R16

  // ----------------------------------------------------------------
  // core-facing strobes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wdt_clear_out     <= 1'b0;
      prefetch_req_out  <= 1'b0;
      prefetch_addr_out <= '0;
      vector_req_out    <= 1'b0;
      vector_addr_out   <= '0;
      device_reset_out  <= 1'b0;
    end else begin
      // sleep-as-no-op leaves the watchdog and its postscaler alone
      wdt_clear_out    <= sleep_take || clr_take;                        // R1
      prefetch_req_out <= sleep_op && in_run;                            // R8
      if (sleep_op && in_run) begin
        prefetch_addr_out <= pc_in + PC_STEP;                            // R8
      end
      vector_req_out   <= (state_q == ST_DUMMY2) && !ext_rst;            // R10
      vector_addr_out  <= IRQ_VECTOR;
      device_reset_out <= ext_rst;                                       // R4
    end
  end

  assign core_run_out        = (state_q != ST_SLEEP) && (state_q != ST_OST);
  assign osc_driver_en_out   = (state_q != ST_SLEEP);                    // R1
  assign exec_prefetched_out = (state_q == ST_EXEC);                     // R10
  assign dummy_cycle_out     = (state_q == ST_DUMMY1) ||
                               (state_q == ST_DUMMY2);                   // R17

  // ----------------------------------------------------------------
  // port hold
  // ----------------------------------------------------------------
  // the core's port logic has no clocks while asleep, so its outputs
  // cannot be trusted; the last awake value is frozen here instead
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      port_data_out <= '0;
      port_oe_out   <= '0;
    end else if (core_run_out && !sleep_take) begin
      port_data_out <= port_data_in;
      port_oe_out   <= port_oe_in;
    end
  end                                                                    // R2

  // ----------------------------------------------------------------
  // registers and interrupt
  // ----------------------------------------------------------------
  logic [NUM_EV-1:0] ev_stat_q;
  logic [NUM_EV-1:0] ev_mask_q;
  logic [NUM_EV-1:0] ev_set;

  always_comb begin
    ev_set = '0;
    ev_set[EV_SLEEP]    = sleep_take;
    ev_set[EV_SLP_NOP]  = sleep_nop;
    ev_set[EV_WAKE_IRQ] = wake_evt && irq_pending;
    ev_set[EV_WAKE_WDT] = wake_evt && !irq_pending;
    ev_set[EV_EXT_RST]  = ext_rst && !device_reset_out;
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_q    <= CTRL_RESET;
      ev_mask_q <= MASK_RESET;
    end else if (reg_wr_in) begin
      if (reg_addr_in == ADDR_CTRL) ctrl_q <= reg_wdata_in;
      if (reg_addr_in == ADDR_IRQ_MASK) ev_mask_q <= reg_wdata_in[NUM_EV-1:0];
    end
  end

  // a new event in the read cycle survives the clear
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ev_stat_q <= '0;
    end else if (reg_rd_in && reg_addr_in == ADDR_IRQ_STAT) begin
      ev_stat_q <= ev_set;
    end else begin
      ev_stat_q <= ev_stat_q | ev_set;
    end
  end

  assign irq_out = |(ev_stat_q & ev_mask_q);

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        ADDR_CTRL:     reg_rdata_out <= ctrl_q;
        ADDR_FLAGS:    reg_rdata_out <= {3'h0, to_q, pd_q, 2'h0, asleep};
        ADDR_IRQ_STAT: reg_rdata_out <= {3'h0, ev_stat_q};
        ADDR_IRQ_MASK: reg_rdata_out <= {3'h0, ev_mask_q};
      endcase
    end else begin
      reg_rdata_out <= '0;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  sleep_effects_a: assert property (sleep_take |=>                  // R1
    !pd_q && wdt_clear_out && !osc_driver_en_out)
    else $error("sleep entry effects missing");

  port_hold_a: assert property (asleep && $past(asleep) |->         // R2
    $stable(port_data_out) && $stable(port_oe_out))
    else $error("port pins moved during sleep");

  pin_reset_a: assert property (asleep && ext_rst |=>               // R4
    device_reset_out && state_q == ST_RUN)
    else $error("pin reset did not end sleep with reset");

  wdt_wake_to_a: assert property (asleep && wdt_wake && !ext_rst    // R5
    && !irq_pending |=> !to_q && !pd_q)
    else $error("watchdog wake did not clear timeout");

  adc_gate_a: assert property (asleep && !ext_rst && !wdt_wake      // R7
    && !adc_rc_clock_in && !(|(irq_flag_in[1:0] & irq_enable_in[1:0]))
    |=> state_q == ST_SLEEP)
    else $error("woke on a disallowed source");

  prefetch_a: assert property (sleep_op && in_run |=>               // R8
    prefetch_req_out && prefetch_addr_out == $past(pc_in) + PC_STEP)
    else $error("prefetch address wrong");

  vector_seq_a: assert property (state_q == ST_EXEC && wake_irq_q   // R10
    && global_irq_enable_in && !ext_rst ##1 !ext_rst [*2] |=>
    vector_req_out && vector_addr_out == IRQ_VECTOR)
    else $error("vector not reached after dummy cycles");

  nop_sleep_a: assert property (sleep_nop |=>                       // R11
    state_q == ST_RUN && $stable(pd_q) && !wdt_clear_out)
    else $error("no-op sleep had side effects");

  ost_delay_a: assert property (asleep && wake_evt && osc_slow      // R13
    |=> !core_run_out [*8])
    else $error("core ran before start-up delay");

  // ----------------------------------------------------------------
  // start-up delay watch
  // ----------------------------------------------------------------
  // a delay range this long slows the tools, so a counter of its own
  // times each stay in the start-up state instead
  logic [OST_CNT_W-1:0] ost_seen_q;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ost_seen_q <= '0;
    end else if (state_q == ST_OST) begin
      ost_seen_q <= ost_seen_q + OST_CNT_W'(1);
    end else begin
      ost_seen_q <= '0;
    end
  end

  wire logic ost_leave = (state_q == ST_OST) && (state_d != ST_OST);

  ost_len_a: assert property (ost_leave && !ext_rst |->             // R13
    ost_seen_q == OST_CNT_W'(OST_CYCLES - 1))
    else $error("start-up delay length wrong");

  ost_hold_a: assert property (state_q == ST_OST && !ext_rst        // R13
    && ost_seen_q < OST_CNT_W'(OST_CYCLES - 1) |=> state_q == ST_OST)
    else $error("start-up delay cut short");

  rc_fast_a: assert property (wake_evt && !osc_slow |=>             // R13
    exec_prefetched_out)
    else $error("rc mode wake should not wait");

  cover_irq_wake_c: cover property (wake_evt && irq_pending ##1
    state_q == ST_EXEC);
  cover_wdt_wake_c: cover property (wake_evt && !irq_pending);
  cover_nop_c: cover property (sleep_nop);
  cover_vector_c: cover property (vector_req_out);

endmodule

/* swc_core_model.sv */
// core-side model: instruction issue and port pin drive
module swc_core_model (
  input  wire logic        clk_sys_in,    // system clock
  input  wire logic        rstn_in,       // reset, active low
  input  wire logic        req_in,        // issue one instruction
  input  wire logic [13:0] op_in,         // opcode to issue
  input  wire logic [12:0] pc_in,         // address of that opcode
  input  wire logic        core_run_in,   // phase clocks running
  output logic             exec_out,      // execute strobe
  output logic      [13:0] instr_out,     // opcode bus
  output logic      [12:0] pc_out,        // address bus
  output logic      [5:0]  port_data_out, // pin drive
  output logic      [5:0]  port_oe_out    // pin enable
);
  // ----------------------------------------------------------------
  // instruction issue
  // ----------------------------------------------------------------
  // a stalled core issues nothing; idle buses toggle so stale values fail
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      exec_out  <= 1'b0;
      instr_out <= 14'h0000;
      pc_out    <= 13'h0000;
    end else begin
      exec_out  <= req_in & core_run_in;
      instr_out <= req_in ? op_in : ~instr_out;
      pc_out    <= req_in ? pc_in : ~pc_out;
    end
  end

  // ----------------------------------------------------------------
  // port drive
  // ----------------------------------------------------------------
  // pins keep moving even while asleep, so a leaky hold shows up
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      port_data_out <= 6'h00;
      port_oe_out   <= 6'h00;
    end else begin
      port_data_out <= port_data_out + 6'h01;
      port_oe_out   <= {port_oe_out[4:0], ~port_oe_out[5]};
    end
  end
endmodule

/* tb.sv */
// self-checking bench of the sleep and wake-up controller
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import swc_pkg::*;

  typedef struct {
    logic [2:0] osc;  // oscillator mode
    int         src;  // wake source, 3 is watchdog
    logic       global_irq_enable;  // global enable
    logic       slow; // start-up delay expected
  } swc_row_type;

  logic        clk_sys_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic        ext_n = 1'b1, global_irq_enable = 1'b0, adc_rc = 1'b0, wdt_to = 1'b0;
  logic [2:0]  flag = 3'h0, en = 3'h0;
  logic [1:0]  raddr = 2'h0;
  logic [7:0]  wdata = 8'h00, d, rdata;
  logic        wr = 1'b0, rd = 1'b0, req = 1'b0, exec;
  logic [13:0] op = 14'h0000, instr;
  logic [12:0] pc_req = 13'h0000, pc, pf_addr, vaddr;
  logic [5:0]  pdat, poe, hdat, hoe, held_d, held_oe;
  logic        irq, dev_rst, run, osc_en, wclr, pd, to, pf_req, exe, dmy;
  logic        vreq;
  int          err_total = 0, comparisons = 0, n;
  swc_row_type rows[6];

  always #5 clk_sys_in = ~clk_sys_in;

  swc_core_model i_core (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .req_in(req),
    .op_in(op), .pc_in(pc_req), .core_run_in(run), .exec_out(exec),
    .instr_out(instr), .pc_out(pc), .port_data_out(pdat),
    .port_oe_out(poe));

  swc_sleep_ctrl i_dut (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .external_reset_pin_n_in(ext_n), .instr_exec_in(exec),
    .instr_in(instr), .pc_in(pc), .global_irq_enable_in(global_irq_enable),
    .irq_flag_in(flag), .irq_enable_in(en), .adc_rc_clock_in(adc_rc),
    .wdt_timeout_in(wdt_to), .port_data_in(pdat), .port_oe_in(poe),
    .reg_addr_in(raddr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .irq_out(irq),
    .device_reset_out(dev_rst), .core_run_out(run),
    .osc_driver_en_out(osc_en), .wdt_clear_out(wclr),
    .power_down_flag_out(pd), .timeout_flag_out(to),
    .prefetch_req_out(pf_req), .prefetch_addr_out(pf_addr),
    .exec_prefetched_out(exe), .dummy_cycle_out(dmy),
    .vector_req_out(vreq), .vector_addr_out(vaddr),
    .port_data_out(hdat), .port_oe_out(hoe));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [12:0] exp,
                     input logic [12:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk_sys_in);
    raddr <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk_sys_in);
    wr    <= 1'b0;
  endtask

  task automatic reg_rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk_sys_in);
    raddr <= a;
    rd    <= 1'b1;
    @(posedge clk_sys_in);
    rd    <= 1'b0;
    #1;
    v = rdata;
  endtask

  // returns one step after the edge that takes the instruction
  task automatic issue(input logic [13:0] o, input logic [12:0] at);
    @(posedge clk_sys_in);
    req    <= 1'b1;
    op     <= o;
    pc_req <= at;
    @(posedge clk_sys_in);
    req    <= 1'b0;
    @(posedge clk_sys_in);
    #1;
  endtask

  task automatic sleep_in(input logic [12:0] at);
    issue(SLEEP_OPCODE, at);
    chk("wdt clear", 1, wclr);
    chk("prefetch", 1, pf_req);
    chk("prefetch addr", at + PC_STEP, pf_addr);
    chk("power_down", 0, pd);
    chk("timeout", 1, to);
    chk("osc driver", 0, osc_en);
    held_d  = hdat;
    held_oe = hoe;
  endtask

  task automatic wait_exe();
    n = 0;
    while (exe !== 1'b1 && n < 1100) begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
  endtask

  task automatic wrap_up();
    if (err_total == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rows = '{'{OSC_CRYSTAL, 0, 1'b1, 1'b1}, '{OSC_HIGH_SPEED, 1, 1'b0, 1'b1},
             '{OSC_LOW_POWER, 2, 1'b1, 1'b1}, '{OSC_INT_RC, 3, 1'b0, 1'b0},
             '{OSC_EXT_RC, 0, 1'b0, 1'b0}, '{OSC_INT_RC, 1, 1'b1, 1'b0}};
    repeat (4) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    @(posedge clk_sys_in);
    #1;
    chk("power_down reset", 1, pd);
    chk("timeout reset", 1, to);
    chk("run reset", 1, run);
    reg_wr(ADDR_IRQ_MASK, 8'h01);
    adc_rc <= 1'b1;
    foreach (rows[i]) begin
      reg_wr(ADDR_CTRL, {4'h0, rows[i].src == 3, rows[i].osc});
      en  <= (rows[i].src < 3) ? 3'(1 << rows[i].src) : 3'h0;
      global_irq_enable <= rows[i].global_irq_enable;
      sleep_in(13'h1ffc + 13'(i));
      repeat (8) @(posedge clk_sys_in);
      #1;
      chk("held data", held_d, hdat);
      chk("held oe", held_oe, hoe);
      chk("asleep", 0, run);
      @(posedge clk_sys_in);
      if (rows[i].src == 3) wdt_to <= 1'b1;
      else flag <= 3'(1 << rows[i].src);
      @(posedge clk_sys_in);
      wdt_to <= 1'b0;
      #1;
      wait_exe();
      chk("wake delay", 1, rows[i].slow ? (n >= 1023 && n <= 1026)
                                        : (n <= 2));
      @(posedge clk_sys_in);
      #1;
      chk("dummy 1", rows[i].global_irq_enable, dmy);
      @(posedge clk_sys_in);
      #1;
      chk("dummy 2", rows[i].global_irq_enable, dmy);
      @(posedge clk_sys_in);
      #1;
      chk("vector", rows[i].global_irq_enable, vreq);
      chk("vector addr", IRQ_VECTOR, vaddr);
      chk("timeout wake", rows[i].src != 3, to);
      chk("power_down wake", 0, pd);
      chk("no reset", 0, dev_rst);
      @(posedge clk_sys_in);
      flag <= 3'h0;
      en   <= 3'h0;
    end
    // disabled sources, disabled watchdog timing out, converter off rc: no wake
    reg_wr(ADDR_CTRL, {5'h00, OSC_INT_RC});
    global_irq_enable    <= 1'b0;
    adc_rc <= 1'b0;
    sleep_in(13'h0040);
    @(posedge clk_sys_in);
    flag   <= 3'h7;
    wdt_to <= 1'b1;
    @(posedge clk_sys_in);
    wdt_to <= 1'b0;
    en     <= 3'h4;
    repeat (20) @(posedge clk_sys_in);
    #1;
    chk("still asleep", 0, run);
    @(posedge clk_sys_in);
    ext_n <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    #1;
    chk("pin reset", 1, dev_rst);
    @(posedge clk_sys_in);
    ext_n <= 1'b1;
    repeat (5) @(posedge clk_sys_in);
    #1;
    chk("run after pin", 1, run);
    chk("timeout pin", 1, to);
    chk("power_down pin", 0, pd);
    // pending enabled source with global enable off
    @(posedge clk_sys_in);
    en     <= 3'h1;
    adc_rc <= 1'b1;
    issue(WDT_CLR_OPCODE, 13'h0041);
    chk("clear pulse", 1, wclr);
    chk("clear power_down", 1, pd);
    chk("clear timeout", 1, to);
    issue(SLEEP_OPCODE, 13'h0042);
    chk("nop no clear", 0, wclr);
    chk("nop prefetch", 1, pf_req);
    chk("nop power_down", 1, pd);
    chk("nop running", 1, run);
    // source fires on the very edge that takes the sleep
    @(posedge clk_sys_in);
    flag   <= 3'h0;
    en     <= 3'h2;
    req    <= 1'b1;
    op     <= SLEEP_OPCODE;
    pc_req <= 13'h0043;
    @(posedge clk_sys_in);
    req  <= 1'b0;
    @(posedge clk_sys_in);
    flag <= 3'h2;
    #1;
    chk("late power_down", 0, pd);
    chk("late wdt clear", 1, wclr);
    wait_exe();
    chk("quick wake", 1, n <= 3);
    @(posedge clk_sys_in);
    flag <= 3'h0;
    en   <= 3'h0;
    #1;
    chk("irq pending", 1, irq);
    reg_rd(ADDR_IRQ_STAT, d);
    chk("stat sleep", 1, d[EV_SLEEP]);
    chk("stat nop", 1, d[EV_SLP_NOP]);
    chk("stat wdt", 1, d[EV_WAKE_WDT]);
    chk("irq cleared", 0, irq);
    reg_rd(ADDR_FLAGS, d);
    chk("flags", 13'(1 << FLG_TIMEOUT), 13'(d));
    wrap_up();
  end

  initial begin
    #200000;
    err_total++;
    $display("Error watchdog expected done seen hang");
    wrap_up();
  end
endmodule
